// >>> include/lit_pkg.sv
// constants and types for the local interrupt timer
package lit_pkg;
    localparam int unsigned ADDR_W  = 12;
    localparam int unsigned DATA_W  = 64;
    localparam int unsigned COUNT_W = 32;
    localparam int unsigned TS_W    = 64;
    localparam int unsigned VEC_W   = 8;
    localparam int unsigned DIV_W   = 3;
    localparam int unsigned PRE_W   = 7;

    localparam logic [ADDR_W-1:0] ADDR_VECTOR_ENTRY = 12'h0320;
    localparam logic [ADDR_W-1:0] ADDR_INIT_COUNT   = 12'h0380;
    localparam logic [ADDR_W-1:0] ADDR_CUR_COUNT    = 12'h0390;
    localparam logic [ADDR_W-1:0] ADDR_DIVIDE       = 12'h03e0;
    localparam logic [ADDR_W-1:0] ADDR_DEADLINE     = 12'h06e0;

    // vector entry field positions
    localparam int unsigned VEC_LSB     = 0;
    localparam int unsigned PENDING_BIT = 12;
    localparam int unsigned MASK_BIT    = 16;
    localparam int unsigned MODE_LO_BIT = 17;
    localparam int unsigned MODE_HI_BIT = 18;

    localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
    localparam logic [1:0] MODE_PERIODIC = 2'h1;
    localparam logic [1:0] MODE_DEADLINE = 2'h2;

    localparam logic              MASK_RESET   = 1'b1;
    localparam logic [COUNT_W-1:0] COUNT_ZERO  = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE   = 32'h0000_0001;
    localparam logic [TS_W-1:0]    TARGET_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [DATA_W-1:0]  DATA_ZERO   = 64'h0000_0000_0000_0000;
    localparam logic [PRE_W-1:0]   PRE_ZERO    = 7'h00;
    localparam logic [PRE_W-1:0]   PRE_ONE     = 7'h01;

    typedef struct packed {
        logic             valid;
        logic [VEC_W-1:0] vector;
    } lit_irq_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lit_req_t;
endpackage

// >>> verilog/lit_timer.sv
// local interrupt timer: count-down, periodic and deadline modes
// Functional notes
// - 32-bit programmable count-down timer
// - tick from bus clock through divider
// - one-shot: initial write loads and starts
// - one-shot: interrupt at zero, hold zero
// - periodic: interrupt, reload, keep counting
// - initial write mid-count restarts from it
// - initial count RW, current count RO
// - writing zero initial count stops timer
// - interrupt carries entry vector, mask suppresses
// - bit 18 reserved without deadline support
// - mode 00 one-shot 01 periodic 10 deadline
// - mode-changing entry write disarms timer
// - deadline mode: ignore initial, current reads zero
// - non-zero target write arms deadline
// - interrupt when timestamp >= target
// - deadline fire disarms and clears target
// - zero target write disarms silently
// - target resets to zero
// - target reads zero, ignores writes outside deadline
// - armed rewrite replaces deadline either way
// - constant-rate timer reported always running
// - unaccepted interrupt offered again until taken
// - pending status while delivered, not accepted
// - mask set at reset, cleared by software
// - timer interrupt always edge triggered
module lit_timer (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    input  wire logic                          reg_valid,
    input  wire lit_pkg::lit_req_t             reg_req,
    output logic      [lit_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic [lit_pkg::TS_W-1:0]      timestamp_counter,
    input  wire logic                          deadline_mode_supported,
    output logic                               always_running_timer_flag,
    output lit_pkg::lit_irq_t                  irq,
    input  wire logic                          irq_accept
);
    // power-of-two ratio as a terminal count mask
    function automatic logic [lit_pkg::PRE_W-1:0] div_mask(
        input logic [lit_pkg::DIV_W-1:0] sel);
        div_mask = (lit_pkg::PRE_ONE << sel) - lit_pkg::PRE_ONE;
    endfunction

    function automatic logic hit(input logic [lit_pkg::ADDR_W-1:0] a);
        hit = reg_valid && reg_req.wr && (reg_req.addr == a);
    endfunction

    logic [lit_pkg::VEC_W-1:0]   vector_reg,   vector_next;
    logic                        mask_reg,     mask_next;
    logic [1:0]                  mode_reg,     mode_next;
    logic [lit_pkg::DIV_W-1:0]   div_reg,      div_next;
    logic [lit_pkg::PRE_W-1:0]   pre_reg,      pre_next;
    logic [lit_pkg::COUNT_W-1:0] init_reg,     init_next;
    logic [lit_pkg::COUNT_W-1:0] cur_reg,      cur_next;
    logic [lit_pkg::TS_W-1:0]    target_reg,   target_next;
    logic                        pend_reg,     pend_next;
    logic [lit_pkg::VEC_W-1:0]   pvec_reg,     pvec_next;
    logic [lit_pkg::DATA_W-1:0]  rdata_reg,    rdata_next;
    logic [1:0]                  wmode;
    logic                        tick;
    logic                        fire;

    always_comb begin
        vector_next = vector_reg;
        mask_next   = mask_reg;
        mode_next   = mode_reg;
        div_next    = div_reg;
        init_next   = init_reg;
        cur_next    = cur_reg;
        target_next = target_reg;
        pend_next   = pend_reg;
        pvec_next   = pvec_reg;
        rdata_next  = rdata_reg;
        fire        = 1'b0;
        // bit 18 only takes effect with deadline support
        wmode = {reg_req.wdata[lit_pkg::MODE_HI_BIT]
                 & deadline_mode_supported,
                 reg_req.wdata[lit_pkg::MODE_LO_BIT]};
        // divider free-runs; one tick per ratio bus clocks
        tick     = (pre_reg & div_mask(div_reg)) == div_mask(div_reg);
        pre_next = tick ? lit_pkg::PRE_ZERO : pre_reg + lit_pkg::PRE_ONE;

        // counting, only in one-shot and periodic modes
        if ((mode_reg == lit_pkg::MODE_ONE_SHOT
             || mode_reg == lit_pkg::MODE_PERIODIC)
            && tick && cur_reg != lit_pkg::COUNT_ZERO) begin
            cur_next = cur_reg - lit_pkg::COUNT_ONE;
            if (cur_reg == lit_pkg::COUNT_ONE) begin
                fire = 1'b1;
                if (mode_reg == lit_pkg::MODE_PERIODIC) begin
                    cur_next = init_reg;
                end
            end
        end
        // deadline compare: non-zero target means armed
        if (mode_reg == lit_pkg::MODE_DEADLINE
            && target_reg != lit_pkg::TARGET_ZERO
            && timestamp_counter >= target_reg) begin
            fire        = 1'b1;
            target_next = lit_pkg::TARGET_ZERO;
        end

        if (hit(lit_pkg::ADDR_VECTOR_ENTRY)) begin
            vector_next = reg_req.wdata[lit_pkg::VEC_LSB +: lit_pkg::VEC_W];
            mask_next   = reg_req.wdata[lit_pkg::MASK_BIT];
            mode_next   = wmode;
            if (wmode != mode_reg) begin
                cur_next    = lit_pkg::COUNT_ZERO;
                target_next = lit_pkg::TARGET_ZERO;
                fire        = 1'b0;
            end
        end
        if (hit(lit_pkg::ADDR_DIVIDE)) begin
            div_next = reg_req.wdata[lit_pkg::DIV_W-1:0];
        end
        if (hit(lit_pkg::ADDR_INIT_COUNT)
            && mode_reg != lit_pkg::MODE_DEADLINE) begin
            init_next = reg_req.wdata[lit_pkg::COUNT_W-1:0];
            // a zero write leaves current at zero, so it stops
            cur_next  = reg_req.wdata[lit_pkg::COUNT_W-1:0];
            fire      = 1'b0;
        end
        if (hit(lit_pkg::ADDR_DEADLINE)
            && mode_reg == lit_pkg::MODE_DEADLINE) begin
            // later or earlier, zero disarms with no event
            target_next = reg_req.wdata;
            fire        = 1'b0;
        end

        // hold the offer until the core takes it
        if (pend_reg && irq_accept) begin
            pend_next = 1'b0;
        end
        // masked expiries are dropped, not deferred
        if (fire && !mask_reg) begin
            pend_next = 1'b1;
            pvec_next = vector_reg;
        end

        rdata_next = lit_pkg::DATA_ZERO;
        if (reg_valid && !reg_req.wr) begin
            case (reg_req.addr)
                lit_pkg::ADDR_VECTOR_ENTRY: begin
                    rdata_next[lit_pkg::VEC_LSB +: lit_pkg::VEC_W] = vector_reg;
                    rdata_next[lit_pkg::PENDING_BIT] = pend_reg;
                    rdata_next[lit_pkg::MASK_BIT]    = mask_reg;
                    rdata_next[lit_pkg::MODE_LO_BIT] = mode_reg[0];
                    rdata_next[lit_pkg::MODE_HI_BIT] = mode_reg[1];
                end
                lit_pkg::ADDR_INIT_COUNT:
                    rdata_next[lit_pkg::COUNT_W-1:0] = init_reg;
                lit_pkg::ADDR_CUR_COUNT: begin
                    if (mode_reg != lit_pkg::MODE_DEADLINE) begin
                        rdata_next[lit_pkg::COUNT_W-1:0] = cur_reg;
                    end
                end
                lit_pkg::ADDR_DIVIDE:
                    rdata_next[lit_pkg::DIV_W-1:0] = div_reg;
                lit_pkg::ADDR_DEADLINE: begin
                    if (mode_reg == lit_pkg::MODE_DEADLINE) begin
                        rdata_next = target_reg;
                    end
                end
                default: rdata_next = lit_pkg::DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vector_reg <= '0;
            mask_reg   <= lit_pkg::MASK_RESET;
            mode_reg   <= lit_pkg::MODE_ONE_SHOT;
            div_reg    <= '0;
            pre_reg    <= lit_pkg::PRE_ZERO;
            init_reg   <= lit_pkg::COUNT_ZERO;
            cur_reg    <= lit_pkg::COUNT_ZERO;
            target_reg <= lit_pkg::TARGET_ZERO;
            pend_reg   <= 1'b0;
            pvec_reg   <= '0;
            rdata_reg  <= lit_pkg::DATA_ZERO;
        end else if (clk_en) begin
            vector_reg <= vector_next;
            mask_reg   <= mask_next;
            mode_reg   <= mode_next;
            div_reg    <= div_next;
            pre_reg    <= pre_next;
            init_reg   <= init_next;
            cur_reg    <= cur_next;
            target_reg <= target_next;
            pend_reg   <= pend_next;
            pvec_reg   <= pvec_next;
            rdata_reg  <= rdata_next;
        end
    end

    // runs on the bus clock alone, so the rate never varies
    assign always_running_timer_flag = 1'b1;
    assign reg_rdata  = rdata_reg;
    assign irq.valid  = pend_reg;
    assign irq.vector = pvec_reg;
endmodule

// >>> tb/lit_core_model.sv
// processor core model accepting timer interrupts after a set delay
module lit_core_model (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire lit_pkg::lit_irq_t irq,
    input  wire logic [3:0]        delay,
    output logic                   irq_accept,
    output int unsigned            taken,
    output logic [7:0]             last_vec
);
    logic [3:0] wait_cnt;
    // a slow core leaves the request standing, so it is offered again
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_accept <= 1'b0;
            wait_cnt <= 4'h0;
            taken <= 0;
            last_vec <= 8'h00;
        end else if (irq.valid && irq_accept) begin
            taken <= taken + 1;
            last_vec <= irq.vector;
            irq_accept <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (irq.valid && wait_cnt == delay) begin
            irq_accept <= 1'b1;
        end else if (irq.valid) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// >>> tb/lit_timer_assertions.sv
// port relations of the local interrupt timer
module lit_timer_assertions (
    input wire logic                       sys_clk,
    input wire logic                       rst,
    input wire logic                       clk_en,
    input wire logic                       reg_valid,
    input wire lit_pkg::lit_req_t          reg_req,
    input wire logic [lit_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                       deadline_mode_supported,
    input wire logic                       always_running_timer_flag,
    input wire lit_pkg::lit_irq_t          irq,
    input wire logic                       irq_accept
);
    logic [18:0] ent_reg;
    // shadow of the entry; bit 18 only sticks when deadline is offered
    always_ff @(posedge sys_clk or posedge rst)
        if (rst) ent_reg <= 19'h1_0000;
        else if (clk_en && reg_valid && reg_req.wr &&
                 reg_req.addr == lit_pkg::ADDR_VECTOR_ENTRY)
            ent_reg <= {reg_req.wdata[18] & deadline_mode_supported,
                        reg_req.wdata[17:0]};
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence rd_s(a);
        clk_en && reg_valid && !reg_req.wr && reg_req.addr == a;
    endsequence
    flag_const_a: assert property (always_running_timer_flag)
        else $error("flag low");
    rdata_idle_a: assert property (clk_en && !reg_valid |=>
        reg_rdata == lit_pkg::DATA_ZERO) else $error("rdata not idle");
    upper_zero_a: assert property (rd_s(lit_pkg::ADDR_CUR_COUNT) |=>
        reg_rdata[63:32] == 32'h0000_0000) else $error("upper bits");
    deadline_cur_a: assert property (rd_s(lit_pkg::ADDR_CUR_COUNT)
        ##0 ent_reg[18:17] == lit_pkg::MODE_DEADLINE |=>
        reg_rdata == lit_pkg::DATA_ZERO) else $error("count seen");
    target_hidden_a: assert property (rd_s(lit_pkg::ADDR_DEADLINE)
        ##0 !ent_reg[18] |=> reg_rdata == lit_pkg::DATA_ZERO)
        else $error("target seen");
    irq_hold_a: assert property (clk_en && irq.valid && !irq_accept
        |=> irq.valid) else $error("request dropped");
    mask_quiet_a: assert property ($rose(irq.valid) |->
        !$past(ent_reg[16])) else $error("masked request");
    vector_copy_a: assert property ($rose(irq.valid) |->
        irq.vector == $past(ent_reg[7:0])) else $error("bad vector");
    stall_freeze_a: assert property (!clk_en |=> $stable(irq) &&
        $stable(reg_rdata)) else $error("moved while stalled");
endmodule
bind lit_timer lit_timer_assertions lit_timer_assertions_i (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_valid(reg_valid),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq),
    .deadline_mode_supported(deadline_mode_supported),
    .always_running_timer_flag(always_running_timer_flag),
    .irq_accept(irq_accept));

// >>> tb/local_interrupt_timer_test.sv
// self-checking bench of the local interrupt timer
module local_interrupt_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic              sys_clk = 0, rst = 1, clk_en = 1, valid = 0;
    logic              dl_sup = 1, flag, acc;
    lit_pkg::lit_req_t req = '0;
    lit_pkg::lit_irq_t irq;
    logic [63:0]       rdata, ts = 0;
    logic [31:0]       seed = 32'hd1fb_efa3;
    logic [7:0]        vec, last_vec;
    logic [3:0]        delay = 0;
    int unsigned       taken, mismatches = 0, comparisons = 0, n, r, t;
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) ts <= ts + 1;
    lit_timer lit_timer_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .reg_valid(valid), .reg_req(req), .reg_rdata(rdata),
        .timestamp_counter(ts), .deadline_mode_supported(dl_sup),
        .always_running_timer_flag(flag), .irq(irq), .irq_accept(acc));
    lit_core_model lit_core_model_i (.sys_clk(sys_clk), .rst(rst),
        .irq(irq), .delay(delay), .irq_accept(acc), .taken(taken),
        .last_vec(last_vec));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [63:0] d, logic w = 1);
        @(posedge sys_clk);
        valid <= 1'b1;
        req <= '{w, a, d};
        @(posedge sys_clk);
        valid <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [11:0] a, logic [63:0] e, string nm);
        wr(a, 64'h0, 1'b0);
        chk(nm, e, rdata);
    endtask
    task automatic wait_fire(int lo, int hi);
        t = 0;
        while (irq.valid !== 1'b1 && t < hi + 8) begin
            @(posedge sys_clk);
            #1 t++;
        end
        chk("fire time", 1, t >= lo && t <= hi);
    endtask
    task automatic quiet(int cyc);
        repeat (8) @(posedge sys_clk);
        #1 n = taken;
        repeat (cyc) @(posedge sys_clk);
        #1 chk("taken", n, taken);
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000 mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(lit_pkg::ADDR_VECTOR_ENTRY, 64'h1_0000, "entry");
        chk("flag", 1, flag);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            vec = seed[7:0];
            r = seed[10:8];
            n = 2 + seed[13:11];
            wr(lit_pkg::ADDR_VECTOR_ENTRY, {56'h0, vec});
            wr(lit_pkg::ADDR_DIVIDE, 64'(r));
            wr(lit_pkg::ADDR_INIT_COUNT, 64'(n));
            wait_fire((n - 1) * (1 << r) + 1, n * (1 << r));
            rd(lit_pkg::ADDR_CUR_COUNT, 0, "held");
            rd(lit_pkg::ADDR_INIT_COUNT, 64'(n), "init");
            chk("vector", vec, last_vec);
        end
        wr(lit_pkg::ADDR_CUR_COUNT, 64'h5);
        rd(lit_pkg::ADDR_CUR_COUNT, 0, "cur");
        // exact cycle counts below need ratio 1, not the random one
        wr(lit_pkg::ADDR_DIVIDE, 64'h0);
        delay <= 4'h3;
        wr(lit_pkg::ADDR_VECTOR_ENTRY, 64'h2_0000 | vec);
        wr(lit_pkg::ADDR_INIT_COUNT, 64'h8);
        wait_fire(8, 8);
        rd(lit_pkg::ADDR_VECTOR_ENTRY, 64'h2_1000 | vec, "pend");
        n = taken;
        repeat (46) @(posedge sys_clk);
        #1 chk("periods", n + 6, taken);
        wr(lit_pkg::ADDR_INIT_COUNT, 64'h0);
        quiet(30);
        delay <= 4'h0;
        wr(lit_pkg::ADDR_INIT_COUNT, 64'd50);
        repeat (10) @(posedge sys_clk);
        wr(lit_pkg::ADDR_INIT_COUNT, 64'h3);
        wait_fire(3, 3);
        wr(lit_pkg::ADDR_VECTOR_ENTRY, {56'h0, vec});
        quiet(20);
        wr(lit_pkg::ADDR_VECTOR_ENTRY, 64'h1_0000 | vec);
        wr(lit_pkg::ADDR_INIT_COUNT, 64'h2);
        quiet(20);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
        wr(lit_pkg::ADDR_VECTOR_ENTRY, 64'h4_0000 | vec);
        rd(lit_pkg::ADDR_DEADLINE, 0, "target");
        wr(lit_pkg::ADDR_INIT_COUNT, 64'h5);
        rd(lit_pkg::ADDR_INIT_COUNT, 64'h2, "kept");
        rd(lit_pkg::ADDR_CUR_COUNT, 0, "cur");
        wr(lit_pkg::ADDR_DEADLINE, ts + 20);
        wait_fire(18, 20);
        rd(lit_pkg::ADDR_DEADLINE, 0, "cleared");
        wr(lit_pkg::ADDR_DEADLINE, ts + 500);
        wr(lit_pkg::ADDR_DEADLINE, ts + 20);
        wait_fire(18, 20);
        wr(lit_pkg::ADDR_DEADLINE, ts + 20);
        wr(lit_pkg::ADDR_DEADLINE, 0);
        quiet(40);
        wr(lit_pkg::ADDR_VECTOR_ENTRY, 64'h6_0000);
        wr(lit_pkg::ADDR_INIT_COUNT, 64'h2);
        quiet(20);
        @(posedge sys_clk) dl_sup <= 1'b0;
        wr(lit_pkg::ADDR_VECTOR_ENTRY, 64'h4_0000 | vec);
        rd(lit_pkg::ADDR_VECTOR_ENTRY, {56'h0, vec}, "entry");
        wr(lit_pkg::ADDR_DEADLINE, 64'h55);
        rd(lit_pkg::ADDR_DEADLINE, 0, "target");
        rd(12'h3f0, 0, "unmapped");
        report_and_stop();
    end
endmodule
